// ===== src/sram_bus_if.sv
// Pin-level interface between the SRAM device and its bus master.
`timescale 1ns/10ps
`include "sram_ctl_regs.svh"
interface sram_bus_if;
    logic                 select_low_first;
    logic                 select_high_second;
    logic                 select_low_third;
    logic                 global_write_n;
    logic                 lane_write_gate_n;
    logic [`LANES-1:0]    lane_write_n;
    logic                 processor_addr_strobe_n;
    logic                 controller_addr_strobe_n;
    logic                 sleep_request;
    logic [`ADDR_W-1:0]   addr;
    logic [`DATA_W-1:0]   dq_from_master;
    logic                 dq_master_oe;
    logic [`DATA_W-1:0]   dq_from_device;
    logic                 dq_device_oe;
    wire  [`DATA_W-1:0]   dq_wire;
    // An undriven bus reads as zero here, so a stray capture shows up as a data mismatch.
    assign dq_wire = dq_device_oe ? dq_from_device :
                     (dq_master_oe ? dq_from_master : '0);
    modport device (
        input  select_low_first, select_high_second, select_low_third,
        input  global_write_n, lane_write_gate_n, lane_write_n,
        input  processor_addr_strobe_n, controller_addr_strobe_n, sleep_request,
        input  addr, dq_from_master, dq_master_oe,
        output dq_from_device, dq_device_oe
    );
    modport master (
        output select_low_first, select_high_second, select_low_third,
        output global_write_n, lane_write_gate_n, lane_write_n,
        output processor_addr_strobe_n, controller_addr_strobe_n, sleep_request,
        output addr, dq_from_master, dq_master_oe,
        input  dq_from_device, dq_device_oe, dq_wire
    );
endinterface : sram_bus_if

// ===== src/sram_ctl_regs.svh
// Constant definitions shared by both ends of the synchronous SRAM link.
`ifndef SRAM_CTL_REGS_SVH
`define SRAM_CTL_REGS_SVH
`define LANES      4
`define LANE_W     8
`define DATA_W     32
`define ADDR_W     8
`define DEPTH      256
`endif

// ===== src/sram_device.sv
// Device end: select decode, write qualification, output turnaround, sleep.
//
// Notes on behaviour
// RL1: Selected only when all three enables active.
// RL2: Full write on global write or all lanes.
// RL3: Data pins stay high-impedance after a write.
// RL4: Drive again only after new strobed read.
// RL5: Master deselects device before asserting sleep.
// RL6: Data pins high-impedance when leaving sleep.
// RL7: Ignore commands asleep; need fresh strobe after.
`timescale 1ns/10ps
`include "sram_ctl_regs.svh"
module sram_device
    import sram_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               reset,
    output logic                    selected,
    output logic                    sleeping,
    output logic                    write_seen,
    output logic                    collision,
    sram_bus_if.device              bus
);
    logic [`DATA_W-1:0]       mem [`DEPTH];
    logic [1:0]               sel_sync_reg;
    logic                     sleep_s1_reg;
    logic                     sleep_reg;
    logic                     rd_stage_reg;
    logic [`ADDR_W-1:0]       rd_addr_reg;
    logic                     drive_reg;
    logic [`DATA_W-1:0]       q_reg;
    logic                     write_seen_reg;
    logic                     collision_reg;
    logic [`DATA_W-1:0]       wmask;

    // Select is the AND of the three enables at their active levels.
    wire chip_sel = !bus.select_low_first && bus.select_high_second
                    && !bus.select_low_third; // RL1
    wire strobe   = !bus.processor_addr_strobe_n || !bus.controller_addr_strobe_n;

    // Lane writes are qualified per lane; the global write overrides all lanes.
    genvar g;
    generate
        for (g = 0; g < `LANES; g = g + 1) begin : g_lane
            wire lane_we = !bus.global_write_n
                           || (!bus.lane_write_gate_n && !bus.lane_write_n[g]); // RL2
            assign wmask[g*`LANE_W +: `LANE_W] = {`LANE_W{lane_we}};
        end
    endgenerate
    wire any_write = !bus.global_write_n
                     || (!bus.lane_write_gate_n && !(&bus.lane_write_n));
    wire full_write = !bus.global_write_n
                      || (!bus.lane_write_gate_n && (bus.lane_write_n == '0)); // RL2

    // The sleep pin is staged through two flops; commands are refused from the first
    // stage on, so a command never straddles the edge at which sleep takes hold.
    wire awake    = !sleep_reg && !sleep_s1_reg;
    wire cmd      = awake && chip_sel && strobe; // RL7
    wire wr_cmd   = cmd && any_write;
    wire rd_cmd   = cmd && !any_write; // RL4

    always_ff @(posedge clk) begin
        if (wr_cmd) begin
            mem[bus.addr] <= (mem[bus.addr] & ~wmask) | (bus.dq_from_master & wmask);
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            sleep_s1_reg   <= 1'b0;
            sleep_reg      <= 1'b0;
            sel_sync_reg   <= 2'h0;
            rd_stage_reg   <= 1'b0;
            rd_addr_reg    <= '0;
            drive_reg      <= 1'b0;
            q_reg          <= '0;
            write_seen_reg <= 1'b0;
            collision_reg  <= 1'b0;
        end else begin
            sleep_s1_reg   <= bus.sleep_request;
            sleep_reg      <= sleep_s1_reg;
            sel_sync_reg   <= {sel_sync_reg[0], chip_sel};
            rd_stage_reg   <= rd_cmd;
            if (rd_cmd) begin
                rd_addr_reg <= bus.addr;
            end
            if (!awake || wr_cmd) begin
                drive_reg <= 1'b0; // RL3 RL6
            end else if (rd_stage_reg) begin
                drive_reg <= 1'b1; // RL4
                q_reg     <= mem[rd_addr_reg];
            end
            write_seen_reg <= wr_cmd && full_write;
            // Flags a sleep request while the master still selects the part.
            collision_reg  <= bus.sleep_request && chip_sel; // RL5
        end
    end

    assign bus.dq_from_device = q_reg;
    assign bus.dq_device_oe   = drive_reg;
    assign selected           = sel_sync_reg[1];
    assign sleeping           = sleep_reg;
    assign write_seen         = write_seen_reg;
    assign collision          = collision_reg;
endmodule : sram_device

// ===== src/sram_master.sv
// Bus master end: turns user read and write requests into SRAM pin cycles.
`timescale 1ns/10ps
`include "sram_ctl_regs.svh"
module sram_master
    import sram_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               reset,
    input  wire logic               req_valid,
    input  wire logic               req_write,
    input  wire logic [`ADDR_W-1:0] req_addr,
    input  wire logic [`DATA_W-1:0] req_wdata,
    input  wire logic               sleep_want,
    output logic                    req_ready,
    output logic                    rd_valid,
    output logic [`DATA_W-1:0]      rd_data,
    output logic                    asleep,
    sram_bus_if.master              bus
);
    ctl_state_t               state_reg;
    ctl_state_t               state_next;
    logic                     cmd_write_reg;
    logic [`ADDR_W-1:0]       addr_reg;
    logic [`DATA_W-1:0]       wdata_reg;
    logic [1:0]               rd_pipe_reg;
    logic                     rd_valid_reg;
    logic [`DATA_W-1:0]       rd_data_reg;
    logic [1:0]               wake_reg;

    wire in_cmd   = (state_reg == CTL_CMD);
    wire in_sleep = (state_reg == CTL_SLEEP);
    // The device stages the sleep pin through two flops and refuses commands until both
    // have cleared, so new requests wait out the same two cycles after sleep ends.
    wire settled  = (wake_reg == 2'h0);
    wire take     = (state_reg == CTL_IDLE) && req_valid && !sleep_want && settled;

    // Sleep is entered only from idle, where every enable is already inactive.
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            CTL_IDLE:  begin
                if (sleep_want) begin
                    state_next = CTL_SLEEP; // RL5
                end else if (req_valid && settled) begin
                    state_next = CTL_CMD;
                end
            end
            CTL_CMD:   state_next = CTL_IDLE;
            CTL_SLEEP: begin
                if (!sleep_want) begin
                    state_next = CTL_IDLE;
                end
            end
            default:   state_next = CTL_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_reg     <= CTL_IDLE;
            cmd_write_reg <= 1'b0;
            addr_reg      <= '0;
            wdata_reg     <= '0;
            rd_pipe_reg   <= 2'h0;
            rd_valid_reg  <= 1'b0;
            rd_data_reg   <= '0;
            wake_reg      <= 2'h0;
        end else begin
            state_reg    <= state_next;
            wake_reg     <= {wake_reg[0], in_sleep};
            rd_pipe_reg  <= {rd_pipe_reg[0], in_cmd && !cmd_write_reg};
            rd_valid_reg <= rd_pipe_reg[1];
            if (rd_pipe_reg[1]) begin
                rd_data_reg <= bus.dq_wire;
            end
            if (take) begin
                cmd_write_reg <= req_write;
                addr_reg      <= req_addr;
                wdata_reg     <= req_wdata;
            end
        end
    end

    // A command cycle selects the part; all other cycles deselect it.
    assign bus.select_low_first         = !in_cmd; // RL1
    assign bus.select_high_second       = in_cmd;
    assign bus.select_low_third         = !in_cmd;
    assign bus.controller_addr_strobe_n = !in_cmd; // RL4
    assign bus.processor_addr_strobe_n  = 1'b1;
    assign bus.global_write_n           = !(in_cmd && cmd_write_reg); // RL2
    assign bus.lane_write_gate_n        = 1'b1;
    assign bus.lane_write_n             = {`LANES{1'b1}};
    assign bus.sleep_request            = in_sleep;
    assign bus.addr                     = addr_reg;
    assign bus.dq_from_master           = wdata_reg;
    assign bus.dq_master_oe             = in_cmd && cmd_write_reg;

    assign req_ready = (state_reg == CTL_IDLE) && !sleep_want && settled;
    assign rd_valid  = rd_valid_reg;
    assign rd_data   = rd_data_reg;
    assign asleep    = in_sleep;
endmodule : sram_master

// ===== src/sram_pkg.sv
// Types shared by the SRAM device model and its controller.
`include "sram_ctl_regs.svh"
package sram_pkg;
    typedef enum logic [2:0] {
        CTL_IDLE  = 3'b001,
        CTL_CMD   = 3'b010,
        CTL_SLEEP = 3'b100
    } ctl_state_t;
    typedef logic [`DATA_W-1:0] word_t;
    typedef logic [`ADDR_W-1:0] addr_t;
endpackage : sram_pkg

// ===== verif/sram_link_chk.sv
// Concurrent checks on the pins between the SRAM master and device.
`timescale 1ns/10ps
`include "sram_ctl_regs.svh"
module sram_link_chk (
    input wire logic              clk,
    input wire logic              reset,
    input wire logic              select_low_first,
    input wire logic              select_high_second,
    input wire logic              select_low_third,
    input wire logic              global_write_n,
    input wire logic              lane_write_gate_n,
    input wire logic [`LANES-1:0] lane_write_n,
    input wire logic              processor_addr_strobe_n,
    input wire logic              controller_addr_strobe_n,
    input wire logic              sleep_request,
    input wire logic              dq_device_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    wire sel  = !select_low_first && select_high_second && !select_low_third;
    wire strb = !processor_addr_strobe_n || !controller_addr_strobe_n;
    wire full = !global_write_n || (!lane_write_gate_n && lane_write_n == '0);
    wire cmd  = sel && strb;
    wire wr   = !global_write_n || (!lane_write_gate_n && !(&lane_write_n));
    a_sel_before_drive: assert property ($rose(dq_device_oe) |-> $past(sel, 2))
        else $error("device drove data without a full select");
    a_strobe_before_drive: assert property ($rose(dq_device_oe) |-> $past(strb && !full, 2))
        else $error("device drove data without a strobed read");
    a_read_drives: assert property (
        (cmd && !wr && !sleep_request && !$past(sleep_request) && !$past(sleep_request, 2))
        ##1 (!sleep_request && !(cmd && wr)) |-> ##1 dq_device_oe)
        else $error("device did not drive two edges after a read");
    a_write_quiet: assert property (cmd && full |=> !dq_device_oe [*2])
        else $error("device drove data after a write");
    a_write_gw_quiet: assert property (cmd && !global_write_n |=> !dq_device_oe)
        else $error("global write not treated as a write");
    a_sleep_entry: assert property ($rose(sleep_request) |-> !sel)
        else $error("sleep requested while selected");
    a_sleep_exit: assert property ($fell(sleep_request) |-> !dq_device_oe [*3])
        else $error("data driven on leaving sleep");
    a_sleep_silent: assert property (sleep_request [*4] |-> !dq_device_oe)
        else $error("data driven while asleep");
endmodule : sram_link_chk

// ===== verif/sync_sram_select_write_sleep_tb_top.sv
// Bench joining both SRAM ends through the pin interface.
`timescale 1ns/10ps
`include "sram_ctl_regs.svh"
module sync_sram_select_write_sleep_tb_top;
    import sram_pkg::*;
    typedef struct {logic wr; addr_t a; word_t d;} row_t;
    logic  clk = 1'b0, reset = 1'b1, req_valid = 1'b0, req_write = 1'b0, sleep_want = 1'b0;
    addr_t req_addr = 8'h00;
    word_t req_wdata = 32'h0, rd_data, got;
    logic  req_ready, rd_valid, asleep, selected, sleeping, write_seen, collision;
    logic  sel_seen = 1'b0;
    int    error_cnt = 0, samples_checked = 0, cycles = 0, n;
    row_t  rows[6] = '{'{1'b1, 8'h00, 32'ha5a5_0f0f}, '{1'b1, 8'hff, 32'h5a5a_f0f0},
                      '{1'b0, 8'h00, 32'ha5a5_0f0f}, '{1'b0, 8'hff, 32'h5a5a_f0f0},
                      '{1'b1, 8'h00, 32'h0000_0001}, '{1'b0, 8'h00, 32'h0000_0001}};
    sram_bus_if bus();
    sram_master sram_master_inst (.clk(clk), .reset(reset), .req_valid(req_valid),
        .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
        .sleep_want(sleep_want), .req_ready(req_ready), .rd_valid(rd_valid),
        .rd_data(rd_data), .asleep(asleep), .bus(bus));
    sram_device sram_device_inst (.clk(clk), .reset(reset), .selected(selected),
        .sleeping(sleeping), .write_seen(write_seen), .collision(collision), .bus(bus));
    sram_link_chk sram_link_chk_inst (.clk(clk), .reset(reset),
        .select_low_first(bus.select_low_first), .select_high_second(bus.select_high_second),
        .select_low_third(bus.select_low_third), .global_write_n(bus.global_write_n),
        .lane_write_gate_n(bus.lane_write_gate_n), .lane_write_n(bus.lane_write_n),
        .processor_addr_strobe_n(bus.processor_addr_strobe_n),
        .controller_addr_strobe_n(bus.controller_addr_strobe_n),
        .sleep_request(bus.sleep_request), .dq_device_oe(bus.dq_device_oe));
    always #5 clk = ~clk;
    task automatic wrap_up;
        $display("checks=%0d errors=%0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up
    task automatic chk(input word_t g, input word_t e);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("Error t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    // Outputs are read at the edge itself, so they show the value sampled there.
    task automatic req(input logic w, input addr_t a, input word_t d, output word_t r);
        int k;
        k = 0;
        @(posedge clk);
        req_valid <= 1'b1;
        req_write <= w;
        req_addr  <= a;
        req_wdata <= d;
        do @(posedge clk); while (req_ready !== 1'b1 && ++k < 20);
        req_valid <= 1'b0;
        k = 0;
        while (k < 20 && (w ? write_seen : rd_valid) !== 1'b1) begin
            @(posedge clk);
            k++;
            sel_seen |= selected;
        end
        r = (k < 20) ? (w ? 32'h1 : rd_data) : 32'hdead_beef;
    endtask : req
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            error_cnt++;
            wrap_up();
        end
    end
    initial begin
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        foreach (rows[i]) begin
            req(rows[i].wr, rows[i].a, rows[i].d, got);
            chk(got, rows[i].wr ? 32'h1 : rows[i].d);
        end
        chk(32'(sel_seen), 32'h1);
        // A sleep request must first drop the select and then hold the data pins quiet.
        sleep_want <= 1'b1;
        n = 0;
        while (sleeping !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        repeat (3) @(posedge clk);
        chk(32'(sleeping), 32'h1);
        chk(32'(req_ready), 32'h0);
        chk(32'(bus.dq_device_oe), 32'h0);
        chk(32'(asleep), 32'h1);
        chk(32'(collision), 32'h0);
        sleep_want <= 1'b0;
        n = 0;
        while (sleeping !== 1'b0 && n < 20) begin
            @(posedge clk);
            n++;
        end
        chk(32'(bus.dq_device_oe), 32'h0);
        req(1'b0, 8'hff, 32'h0, got);
        chk(got, 32'h5a5a_f0f0);
        reset <= 1'b1;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        chk(32'({selected, asleep, bus.dq_device_oe}), 32'h0);
        wrap_up();
    end
endmodule : sync_sram_select_write_sleep_tb_top
